// ===== rtl/adc_input_port_frontend.sv
// four adc input ports with complex pairing, channel crossbar, pad mode and clock rate multiplier
// assumes control bits held steady by software; port clocks much slower than clk
`timescale 1ns/1ns
module adc_input_port_frontend
    import adc_frontend_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [NUM_PORTS-1:0]  port_sample_clock,
    input  wire logic [NUM_PORTS-1:0]  clk_invert,
    input  wire logic [MANT_W-1:0]     port_a_mantissa,
    input  wire logic [MANT_W-1:0]     port_b_mantissa,
    input  wire logic [MANT_W-1:0]     port_c_mantissa,
    input  wire logic [MANT_W-1:0]     port_d_mantissa,
    input  wire logic [EXP_W-1:0]      port_a_scale_pins,
    input  wire logic [EXP_W-1:0]      port_b_scale_pins,
    input  wire logic [EXP_W-1:0]      port_c_scale_pins,
    input  wire logic [EXP_W-1:0]      port_d_scale_pins,
    input  wire logic [NUM_PORTS-1:0]  gain_ctrl_en,
    input  wire logic [4*EXP_W-1:0]    gain_code,
    output logic      [4*EXP_W-1:0]    scale_pins_out_r,
    output logic      [NUM_PORTS-1:0]  scale_pins_oe_n_r,
    input  wire logic                  pair_ab_en,
    input  wire logic                  pair_cd_en,
    input  wire logic [XBAR_W*CH-1:0]  ch_xbar_sel,
    input  wire logic [CH-1:0]         ch_complex_sel,
    output logic      [MANT_W*CH-1:0]  ch_i_data_r,
    output logic      [MANT_W*CH-1:0]  ch_q_data_r,
    output logic      [CH-1:0]         ch_valid_r,
    input  wire logic                  diff_ctrl_wr,
    input  wire logic                  diff_single_ended_bit,
    input  wire logic                  diff_cal_bit,
    output logic                       diff_mode_r,
    output logic                       cal_busy_r,
    input  wire logic [MULT_W-1:0]     pll_mult,
    input  wire logic [PREDIV_W-1:0]   pll_prediv,
    output logic                       pll_bypass_r,
    output logic                       proc_clk_tick_r
);
    // elaboration check: channel count the crossbar can serve
    if (CH < 1 || CH > 8) begin : g_bad_ch
        $error("adc_input_port_frontend: channel count out of range");
    end

    logic [MANT_W-1:0]    mant_pins [NUM_PORTS];
    logic [EXP_W-1:0]     exp_pins  [NUM_PORTS];
    logic [MANT_W-1:0]    sample    [NUM_PORTS];
    logic [NUM_PORTS-1:0] valid;
    logic [NUM_PORTS-1:0] ovr_en;
    logic [EXP_W-1:0]     ovr_code  [NUM_PORTS];
    logic [NUM_PORTS-1:0] drive_en;
    logic [NUM_PORTS-1:0] leg_valid;
    logic [NUM_PORTS-1:0] port_clk_eff;

    // pin groups in port order
    always_comb begin
        mant_pins[0] = port_a_mantissa;
        mant_pins[1] = port_b_mantissa;
        mant_pins[2] = port_c_mantissa;
        mant_pins[3] = port_d_mantissa;
        exp_pins[0]  = port_a_scale_pins;
        exp_pins[1]  = port_b_scale_pins;
        exp_pins[2]  = port_c_scale_pins;
        exp_pins[3]  = port_d_scale_pins;
    end

    // exponent pin direction and the code each port rescales with
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            drive_en[p] = gain_ctrl_en[p];
            ovr_en[p]   = gain_ctrl_en[p];
            ovr_code[p] = gain_code[p*EXP_W +: EXP_W];
        end
        // in single-ended pad mode the second port of a pair follows the first and never drives
        if (pair_ab_en && !diff_mode_r) begin
            drive_en[1] = 1'b0;
            ovr_en[1]   = gain_ctrl_en[0];
            ovr_code[1] = gain_code[0 +: EXP_W];
        end
        if (pair_cd_en && !diff_mode_r) begin
            drive_en[3] = 1'b0;
            ovr_en[3]   = gain_ctrl_en[2];
            ovr_code[3] = gain_code[2*EXP_W +: EXP_W];
        end
        // differential legs B and D keep their own clock but offer no valid sample to the crossbar
        port_clk_eff = port_sample_clock;
        leg_valid    = valid;
        if (diff_mode_r) begin
            leg_valid[1] = 1'b0;
            leg_valid[3] = 1'b0;
        end
    end

    // one capture path per port
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        adc_port_capture #(
            .MW (MANT_W),
            .EW (EXP_W)
        ) u_capture (
            .clk             (clk),
            .rst             (rst),
            .port_clk        (port_clk_eff[p]),
            .clk_invert      (clk_invert[p]),
            .mant_pin        (mant_pins[p]),
            .exp_pin         (exp_pins[p]),
            .exp_override_en (ovr_en[p]),
            .exp_override    (ovr_code[p]),
            .sample_r        (sample[p]),
            .valid_r         (valid[p])
        );
    end

    logic [MANT_W*CH-1:0] ch_i_nxt, ch_q_nxt;
    logic [CH-1:0]        ch_valid_nxt;
    logic [4*EXP_W-1:0]   scale_out_nxt;
    logic [NUM_PORTS-1:0] scale_oe_n_nxt;

    // crossbar: real or complex source per channel
    always_comb begin
        logic [XBAR_W-1:0] sel;
        sel           = '0;
        ch_i_nxt      = ch_i_data_r;
        ch_q_nxt      = ch_q_data_r;
        ch_valid_nxt  = '0;
        for (int c = 0; c < CH; c++) begin
            sel = ch_xbar_sel[c*XBAR_W +: XBAR_W];
            if (sel == SEL_PORT_A || sel == SEL_PORT_B || sel == SEL_PORT_C || sel == SEL_PORT_D) begin
                if (leg_valid[sel[1:0]]) begin
                    ch_valid_nxt[c]           = 1'b1;
                    ch_i_nxt[c*MANT_W +: MANT_W] = sample[sel[1:0]];
                    ch_q_nxt[c*MANT_W +: MANT_W] = '0;
                    // complex pick on the first port of an enabled pair
                    if (ch_complex_sel[c] && !diff_mode_r) begin
                        if (sel == SEL_PORT_A && pair_ab_en) begin
                            ch_q_nxt[c*MANT_W +: MANT_W] = sample[1];
                        end else if (sel == SEL_PORT_C && pair_cd_en) begin
                            ch_q_nxt[c*MANT_W +: MANT_W] = sample[3];
                        end
                    end
                end
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            scale_out_nxt[p*EXP_W +: EXP_W] = drive_en[p] ? gain_code[p*EXP_W +: EXP_W] : '0;
            scale_oe_n_nxt[p]               = ~drive_en[p];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch_i_data_r       <= '0;
            ch_q_data_r       <= '0;
            ch_valid_r        <= '0;
            scale_pins_out_r  <= '0;
            scale_pins_oe_n_r <= '1;
        end else begin
            ch_i_data_r       <= ch_i_nxt;
            ch_q_data_r       <= ch_q_nxt;
            ch_valid_r        <= ch_valid_nxt;
            scale_pins_out_r  <= scale_out_nxt;
            scale_pins_oe_n_r <= scale_oe_n_nxt;
        end
    end

    // pad mode and calibration sequencer
    cal_state_t           cal_state_r, cal_state_nxt;
    logic [CAL_CNT_W-1:0] cal_cnt_r, cal_cnt_nxt;
    logic                 diff_mode_nxt, cal_busy_nxt;

    always_comb begin
        diff_mode_nxt = diff_mode_r;
        cal_state_nxt = cal_state_r;
        cal_cnt_nxt   = cal_cnt_r;
        if (diff_ctrl_wr) begin
            diff_mode_nxt = ~diff_single_ended_bit;
        end
        case (cal_state_r)
            CAL_IDLE: begin
                if (diff_ctrl_wr && diff_cal_bit) begin
                    cal_state_nxt = CAL_RUN;
                    cal_cnt_nxt   = CAL_CNT_W'(CAL_CYCLES - 1);
                end
            end
            CAL_RUN: begin
                if (cal_cnt_r == '0) begin
                    cal_state_nxt = CAL_IDLE;
                end else begin
                    cal_cnt_nxt = cal_cnt_r - 1'b1;
                end
            end
            default: begin
                cal_state_nxt = CAL_IDLE;
                cal_cnt_nxt   = '0;
            end
        endcase
        cal_busy_nxt = (cal_state_nxt == CAL_RUN);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            diff_mode_r <= DIFF_RESET;
            cal_state_r <= CAL_IDLE;
            cal_cnt_r   <= '0;
            cal_busy_r  <= 1'b0;
        end else begin
            diff_mode_r <= diff_mode_nxt;
            cal_state_r <= cal_state_nxt;
            cal_cnt_r   <= cal_cnt_nxt;
            cal_busy_r  <= cal_busy_nxt;
        end
    end

    // processing clock rate: credit of M per port A sample, one tick per N of credit
    logic [MULT_W-1:0]   mult_r;
    logic [PREDIV_W-1:0] prediv_r;
    logic [CREDIT_W-1:0] credit_r, credit_nxt;
    logic                tick_nxt, bypass_nxt;
    logic [CREDIT_W-1:0] inc, div, sum;

    always_comb begin
        bypass_nxt = (mult_r < MULT_MIN) || (mult_r > MULT_MAX);
        inc        = bypass_nxt ? CREDIT_W'(1) : CREDIT_W'(mult_r);
        case (prediv_r)
            PREDIV_1: div = CREDIT_W'(1);
            PREDIV_2: div = CREDIT_W'(2);
            PREDIV_4: div = CREDIT_W'(4);
            PREDIV_8: div = CREDIT_W'(8);
            default:  div = CREDIT_W'(1);
        endcase
        if (bypass_nxt) begin
            div = CREDIT_W'(1);
        end
        sum      = credit_r + (valid[0] ? inc : '0);
        tick_nxt = (sum >= div);
        credit_nxt = tick_nxt ? sum - div : sum;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mult_r          <= MULT_RESET;
            prediv_r        <= PREDIV_RESET;
            credit_r        <= '0;
            proc_clk_tick_r <= 1'b0;
            pll_bypass_r    <= 1'b1;
        end else begin
            mult_r          <= pll_mult;
            prediv_r        <= pll_prediv;
            credit_r        <= credit_nxt;
            proc_clk_tick_r <= tick_nxt;
            pll_bypass_r    <= bypass_nxt;
        end
    end
endmodule : adc_input_port_frontend

// ===== inc/adc_frontend_pkg.sv
// shared constants for the adc input port front end
// assumes one 20 MHz system clock; all control bits arrive as plain ports
package adc_frontend_pkg;
    localparam int MANT_W      = 16;    // mantissa width per port
    localparam int EXP_W       = 3;     // exponent width per port
    localparam int XBAR_W      = 3;     // crossbar selector width
    localparam int NUM_PORTS   = 4;
    localparam int NUM_CH      = 6;     // processing channels served
    localparam int MULT_W      = 5;     // multiplier field width
    localparam int PREDIV_W    = 2;     // predivider field width
    localparam int CREDIT_W    = 8;     // rate credit accumulator width

    // crossbar codes
    localparam logic [XBAR_W-1:0] SEL_PORT_A = 3'h0;
    localparam logic [XBAR_W-1:0] SEL_PORT_B = 3'h1;
    localparam logic [XBAR_W-1:0] SEL_PORT_C = 3'h2;
    localparam logic [XBAR_W-1:0] SEL_PORT_D = 3'h3;

    // multiplier valid range, anything else is bypass
    localparam logic [MULT_W-1:0] MULT_MIN = 5'h04;
    localparam logic [MULT_W-1:0] MULT_MAX = 5'h14;

    // predivider codes
    localparam logic [PREDIV_W-1:0] PREDIV_1 = 2'h0;
    localparam logic [PREDIV_W-1:0] PREDIV_2 = 2'h1;
    localparam logic [PREDIV_W-1:0] PREDIV_4 = 2'h2;
    localparam logic [PREDIV_W-1:0] PREDIV_8 = 2'h3;

    // values after reset
    localparam logic [MULT_W-1:0]   MULT_RESET   = 5'h00;  // bypass
    localparam logic [PREDIV_W-1:0] PREDIV_RESET = 2'h0;
    localparam logic                DIFF_RESET   = 1'b0;   // single-ended

    // pad calibration duration
    localparam int CLK_PERIOD_NS = 50;
    localparam int CAL_TIME_NS   = 2000;
    localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CNT_W     = 8;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } cal_state_t;
endpackage : adc_frontend_pkg

// ===== rtl/adc_port_capture.sv
// one adc input port: pin synchroniser, edge-selected capture and exponent rescale
// assumes port clock, mantissa and exponent pins are asynchronous to clk
`timescale 1ns/1ns
module adc_port_capture
    import adc_frontend_pkg::*;
#(
    parameter int MW = MANT_W,
    parameter int EW = EXP_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          port_clk,
    input  wire logic          clk_invert,
    input  wire logic [MW-1:0] mant_pin,
    input  wire logic [EW-1:0] exp_pin,
    input  wire logic          exp_override_en,
    input  wire logic [EW-1:0] exp_override,
    output logic      [MW-1:0] sample_r,
    output logic               valid_r
);
    // elaboration check: widths the shifter and pin groups can serve
    if (MW < 2 || EW < 1 || EW > 4) begin : g_bad_width
        $error("adc_port_capture: unsupported widths");
    end

    logic [2:0]    clk_sync_r;
    logic [MW-1:0] mant1_r, mant2_r, mant3_r;
    logic [EW-1:0] exp1_r, exp2_r, exp3_r;
    logic          level_r, level_nxt;
    logic [MW-1:0] sample_nxt;
    logic          valid_nxt;
    logic          agree;
    logic [EW-1:0] shift;

    // level changes once stages two and three agree; capture on the chosen edge
    always_comb begin
        agree      = (clk_sync_r[1] == clk_sync_r[2]);
        level_nxt  = agree ? clk_sync_r[2] : level_r;
        shift      = exp_override_en ? exp_override : exp3_r;
        valid_nxt  = 1'b0;
        sample_nxt = sample_r;
        if (agree && (clk_sync_r[2] != level_r) && (clk_sync_r[2] == ~clk_invert)) begin
            valid_nxt  = 1'b1;
            sample_nxt = MW'($signed(mant3_r) >>> shift);
        end
    end

    // three-stage synchronisers and capture registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_sync_r <= 3'h0;
            mant1_r    <= '0;
            mant2_r    <= '0;
            mant3_r    <= '0;
            exp1_r     <= '0;
            exp2_r     <= '0;
            exp3_r     <= '0;
            level_r    <= 1'b0;
            sample_r   <= '0;
            valid_r    <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[1:0], port_clk};
            mant1_r    <= mant_pin;
            mant2_r    <= mant1_r;
            mant3_r    <= mant2_r;
            exp1_r     <= exp_pin;
            exp2_r     <= exp1_r;
            exp3_r     <= exp2_r;
            level_r    <= level_nxt;
            sample_r   <= sample_nxt;
            valid_r    <= valid_nxt;
        end
    end
endmodule : adc_port_capture

// ===== testbench/adc_frontend_checker.sv
// checker: timing of the front end's control, status and channel ports
// assumes one clk domain; bound into every adc_input_port_frontend
`timescale 1ns/1ns
module adc_frontend_checker
    import adc_frontend_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [NUM_PORTS-1:0] gain_ctrl_en,
    input wire logic [NUM_PORTS-1:0] scale_pins_oe_n_r,
    input wire logic                 pair_ab_en,
    input wire logic [XBAR_W*CH-1:0] ch_xbar_sel,
    input wire logic [CH-1:0]        ch_complex_sel,
    input wire logic [MANT_W*CH-1:0] ch_q_data_r,
    input wire logic [CH-1:0]        ch_valid_r,
    input wire logic                 diff_ctrl_wr,
    input wire logic                 diff_single_ended_bit,
    input wire logic                 diff_cal_bit,
    input wire logic                 diff_mode_r,
    input wire logic                 cal_busy_r,
    input wire logic [MULT_W-1:0]    pll_mult,
    input wire logic                 pll_bypass_r
);
    int busy_cnt;
    // counts consecutive calibration busy cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) busy_cnt <= 0;
        else busy_cnt <= cal_busy_r ? busy_cnt + 1 : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_OE_B: assert property (pair_ab_en [*2] |-> scale_pins_oe_n_r[1])
        else $error("paired port b drives its exponent pins");
    AST_OE_A: assert property (gain_ctrl_en[0] [*2] |-> !scale_pins_oe_n_r[0])
        else $error("port a exponent pins not driven");
    AST_NOSRC: assert property (ch_xbar_sel[14] [*2] |-> !ch_valid_r[4])
        else $error("channel without source gave a sample");
    AST_QREAL: assert property (ch_valid_r[5] && !$past(ch_complex_sel[5]) |-> ch_q_data_r[95:80] == 16'h0000)
        else $error("real channel has nonzero q");
    AST_QPAIR: assert property (ch_valid_r[0] && !$past(pair_ab_en) |-> ch_q_data_r[15:0] == 16'h0000)
        else $error("unpaired complex channel has nonzero q");
    AST_CAL_GO: assert property (diff_ctrl_wr && diff_cal_bit && !cal_busy_r |=> cal_busy_r)
        else $error("calibration did not start");
    AST_CAL_LEN: assert property ($fell(cal_busy_r) |-> busy_cnt == CAL_CYCLES)
        else $error("calibration length wrong");
    AST_MODE: assert property (diff_ctrl_wr |=> diff_mode_r == !$past(diff_single_ended_bit))
        else $error("pad mode not taken from write");
    AST_MODE_HOLD: assert property (!diff_ctrl_wr |=> $stable(diff_mode_r))
        else $error("pad mode changed without write");
    AST_BYPASS: assert property ($stable(pll_mult) |=>
        pll_bypass_r == ($past(pll_mult) < MULT_MIN || $past(pll_mult) > MULT_MAX))
        else $error("multiplier bypass wrong");
    AST_VALID_PULSE: assert property (ch_valid_r[0] |=> !ch_valid_r[0])
        else $error("channel valid stood longer than one cycle");
    AST_RST: assert property ($fell(rst) |-> pll_bypass_r && !diff_mode_r && &scale_pins_oe_n_r)
        else $error("idle state wrong after reset");
endmodule : adc_frontend_checker
bind adc_input_port_frontend adc_frontend_checker #(.CH(CH)) i_chk (.clk(clk), .rst(rst),
    .gain_ctrl_en(gain_ctrl_en), .scale_pins_oe_n_r(scale_pins_oe_n_r), .pair_ab_en(pair_ab_en),
    .ch_xbar_sel(ch_xbar_sel), .ch_complex_sel(ch_complex_sel), .ch_q_data_r(ch_q_data_r),
    .ch_valid_r(ch_valid_r), .diff_ctrl_wr(diff_ctrl_wr), .diff_single_ended_bit(diff_single_ended_bit),
    .diff_cal_bit(diff_cal_bit), .diff_mode_r(diff_mode_r), .cal_busy_r(cal_busy_r),
    .pll_mult(pll_mult), .pll_bypass_r(pll_bypass_r));

// ===== testbench/adc_source_model.sv
// adc source model: four converters, one word per port clock pulse
// assumes req pulses from the bench; data inverted once its hold time is over
`timescale 1ns/1ns
module adc_source_model
    import adc_frontend_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic [NUM_PORTS-1:0] req,
    input  wire logic [4*MANT_W-1:0]  word,
    input  wire logic [4*EXP_W-1:0]   expo,
    output logic      [NUM_PORTS-1:0] pclk,
    output logic      [4*MANT_W-1:0]  mant,
    output logic      [4*EXP_W-1:0]   expi,
    output logic      [NUM_PORTS-1:0] busy
);
    int cnt [NUM_PORTS] = '{default: 0};
    initial begin
        pclk = '0; mant = '0; expi = '0; busy = '0;
    end
    // per port frame: data out, rise at 4, fall at 8, release at 14
    always @(posedge clk) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (cnt[p] == 0 && req[p]) begin
                mant[p*16 +: 16] <= word[p*16 +: 16];
                expi[p*3 +: 3]   <= expo[p*3 +: 3];
                busy[p]          <= 1'b1;
                cnt[p]           <= 1;
            end else if (cnt[p] != 0) begin
                cnt[p] <= (cnt[p] == 14) ? 0 : cnt[p] + 1;
                if (cnt[p] == 4) pclk[p] <= 1'b1;
                if (cnt[p] == 8) pclk[p] <= 1'b0;
                if (cnt[p] == 14) begin
                    mant[p*16 +: 16] <= ~mant[p*16 +: 16];
                    expi[p*3 +: 3]   <= ~expi[p*3 +: 3];
                    busy[p]          <= 1'b0;
                end
            end
        end
    end
endmodule : adc_source_model

// ===== testbench/adc_input_port_frontend_test.sv
// testbench: port traffic, pairing, pad mode, calibration and rate multiplier
// assumes adc_source_model feeds all four ports; inputs change at falling clk
`timescale 1ns/1ns
module adc_input_port_frontend_test
    import adc_frontend_pkg::*;
;
    localparam logic [10:0] PT [7] = '{11'h001, 11'h214, 11'h525, 11'h432, 11'h0D1, 11'h541, 11'h104};
    logic        clk = 1'b0, rst = 1'b1, pab = 1'b0, pcd = 1'b0, wr = 1'b0, se = 1'b1, cal = 1'b0;
    logic [3:0]  req = '0, inv = '0, gen = '0, busy, pclk, oe_n;
    logic [63:0] word = '0, mant;
    logic [11:0] expo = '0, gcode = 12'h143, expi, pins_out;
    logic [17:0] xsel = {3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    logic [5:0]  csel = 6'h05, chv;
    logic [95:0] chi, chq;
    logic [4:0]  mult = '0;
    logic [1:0]  prediv = '0;
    logic        mode, cbusy, byp, tick;
    int          n_errors = 0, n_tests = 0, n_tick = 0, n_vld = 0;
    adc_source_model i_src (.clk(clk), .req(req), .word(word), .expo(expo), .pclk(pclk), .mant(mant),
        .expi(expi), .busy(busy));
    adc_input_port_frontend i_dut (.clk(clk), .rst(rst), .port_sample_clock(pclk), .clk_invert(inv),
        .port_a_mantissa(mant[15:0]), .port_b_mantissa(mant[31:16]), .port_c_mantissa(mant[47:32]),
        .port_d_mantissa(mant[63:48]), .port_a_scale_pins(expi[2:0]), .port_b_scale_pins(expi[5:3]),
        .port_c_scale_pins(expi[8:6]), .port_d_scale_pins(expi[11:9]), .gain_ctrl_en(gen),
        .gain_code(gcode), .scale_pins_out_r(pins_out), .scale_pins_oe_n_r(oe_n), .pair_ab_en(pab),
        .pair_cd_en(pcd), .ch_xbar_sel(xsel), .ch_complex_sel(csel), .ch_i_data_r(chi), .ch_q_data_r(chq),
        .ch_valid_r(chv), .diff_ctrl_wr(wr), .diff_single_ended_bit(se), .diff_cal_bit(cal),
        .diff_mode_r(mode), .cal_busy_r(cbusy), .pll_mult(mult), .pll_prediv(prediv),
        .pll_bypass_r(byp), .proc_clk_tick_r(tick));
    always #25 clk = ~clk;
    // counts processing clock ticks and channel 0 valid pulses where they are settled
    always @(negedge clk) begin
        if (tick === 1'b1) n_tick++;
        if (chv[0] === 1'b1) n_vld++;
    end
    function automatic logic [15:0] sc(input logic [15:0] m, input logic [2:0] e);
        return 16'($signed(m) >>> e);
    endfunction : sc
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // one sample frame on the ports in m, bounded wait for its end
    task automatic send(input logic [3:0] m);
        int i;
        req = m;
        @(negedge clk);
        req = '0;
        for (i = 0; i < 40 && busy !== 4'h0; i++) @(negedge clk);
        if (busy !== 4'h0) begin
            n_errors++;
            wrap_up();
        end
        repeat (6) @(negedge clk);
    endtask : send
    task automatic dwr(input logic s, input logic c);
        se = s; cal = c; wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : dwr
    initial begin
        int k, i;
        logic [2:0] ea, eb, ec, ed;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(16'({byp, mode, oe_n}), 16'h002F);
        // exponent codes, edges and pairings across eight passes
        for (k = 0; k < 8; k++) begin
            word = {16'h4567 ^ 16'(k), 16'hC001, 16'h7F0E, 16'h8123 + 16'(k)};
            expo = {3'(k ^ 5), 3'(k + 2), 3'(7 - k), 3'(k)};
            pab = k[0]; pcd = k[1]; inv = 4'(k * 5); gen = (k == 7) ? 4'hF : 4'h0;
            ea = gen[0] ? 3'h3 : expo[2:0]; eb = gen[0] ? 3'h3 : expo[5:3];
            ec = gen[2] ? 3'h5 : expo[8:6]; ed = gen[2] ? 3'h5 : expo[11:9];
            @(negedge clk);
            send(4'hA);
            send(4'h5);
            chk(chi[15:0], sc(word[15:0], ea));
            chk(chq[15:0], pab ? sc(word[31:16], eb) : 16'h0000);
            chk(chi[31:16], sc(word[31:16], eb));
            chk(chi[47:32], sc(word[47:32], ec));
            chk(chq[47:32], pcd ? sc(word[63:48], ed) : 16'h0000);
            chk(chi[63:48], sc(word[63:48], ed));
            chk(chi[95:80], sc(word[15:0], ea));
            if (k == 7) chk(16'({oe_n, pins_out[8:6], pins_out[2:0]}), 16'h02AB);
        end
        $display("test ports done");
        gen = 4'h0; pab = 1'b0; pcd = 1'b0;
        dwr(1'b0, 1'b0);
        chk(16'(mode), 16'h0001);
        word = ~word;
        send(4'hA);
        chk(chi[31:16], sc(~word[31:16], 3'h3));
        send(4'h5);
        chk(chi[15:0], sc(word[15:0], expo[2:0]));
        dwr(1'b1, 1'b0);
        chk(16'(mode), 16'h0000);
        $display("test pad mode done");
        dwr(1'b1, 1'b1);
        chk(16'(cbusy), 16'h0001);
        repeat (9) @(negedge clk);
        dwr(1'b1, 1'b1);
        for (i = 0; i < 60 && cbusy === 1'b1; i++) @(negedge clk);
        if (cbusy !== 1'b0) begin
            n_errors++;
            wrap_up();
        end
        chk(16'(i), 16'(CAL_CYCLES - 10));
        $display("test calibration done");
        // multiplier and predivider table: M, N code, ticks per port a sample
        // port a now fed as a fixed-point converter: exponent low, 11-bit word msb-justified
        expo = '0;
        word[15:0] = 16'hA5E0;
        for (k = 0; k < 7; k++) begin
            {mult, prediv} = 7'(PT[k] >> 4);
            repeat (3) @(negedge clk);
            n_tick = 0;
            n_vld = 0;
            send(4'h1);
            chk(16'(n_tick), 16'(PT[k][3:0]));
            chk(16'(n_vld), 16'h0001);
            chk(chi[15:0], word[15:0]);
            chk(16'(byp), 16'(k == 0 || k == 4 || k == 5));
        end
        $display("test multiplier done");
        wrap_up();
    end
endmodule : adc_input_port_frontend_test
